// File: rtl/pbs_sequencer.v
// front-panel program and beam sequencer with apb setpoint access
`timescale 1ns/100ps
`default_nettype none
`include "pbs_defs.vh"

// How it works
// - four stored programs; each program press steps to the next, one led each
// - program press while running previews next program setpoints for four seconds
// - another press inside the preview advances it and restarts the wait
// - preview ending on the running program changes nothing, else values ramp over
// - closed-loop beam mode steers rf power so beam current meets its setpoint
// - four gas channels; gas press shows the next channel's flow setpoint
// - rf setpoint edits in closed-loop only in standby, other modes anytime
// - discharge press from standby starts only the discharge
// - beam press from standby enables beam and, interlocked, the discharge
// - discharge and beam leds flash until setpoints are reached, then stay lit
// - closed-loop: beam press while beam runs drops back to discharge only
// - discharge press while running puts everything into standby
// - any setpoint edit activates the edit slot and flashes the program led
// - holding acquire stores the edit slot into its program, then flashing stops
// - the edit slot is cleared by reset and does not survive power loss
// - another program that starts running while editing discards the edit slot
// - after standby with edits, next enable runs them unless another program chosen
// - while editing, program presses cycle four programs plus the edit slot
// - in standby a program press leaves a changed discharge for the stored program
// - open-loop sequences like closed-loop but without beam-current feedback
// - open-loop: beam press starts the program, discharge press stops all units
// - setpoint led before enable and run led with running values after
// - mode button cycles gas-only, closed-loop and open-loop, one led each
// - a missing supply link flashes a numbered fault code on the panel
module pbs_sequencer #(
	parameter [29:0] PREVIEW_CYC = `PBS_PREVIEW_MS * `PBS_CLK_KHZ,
	parameter [29:0] DEBOUNCE_CYC = `PBS_DEBOUNCE_MS * `PBS_CLK_KHZ,
	parameter [29:0] BLINK_CYC = `PBS_BLINK_MS * `PBS_CLK_KHZ,
	parameter [29:0] TICK_CYC = `PBS_TICK_MS * `PBS_CLK_KHZ
)(
	// clock and reset
	input wire pclk,
	input wire presetn,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// panel buttons, high while pressed
	input wire btn_prog,
	input wire btn_gas,
	input wire btn_mode,
	input wire btn_dis,
	input wire btn_beam,
	input wire btn_acq,
	// supply side
	input wire [3:0] link_ok,
	input wire at_setpoint,
	input wire [15:0] beam_meas,
	output reg dis_en_q,
	output reg beam_en_q,
	output reg [2:0] sp_field_q,
	output reg [15:0] sp_value_q,
	output reg sp_valid_q,
	// panel indicators and display
	output reg [3:0] prog_led_q,
	output reg [2:0] mode_led_q,
	output reg standby_led_q,
	output reg discharge_led_q,
	output reg beam_led_q,
	output reg setpoint_led_q,
	output reg run_led_q,
	output reg [3:0] gas_led_q,
	output reg [15:0] disp_gas_q,
	output reg [3:0] fault_code_display_q
);

	integer i;
	// each clocked process keeps its own loop variable so no variable has two drivers
	integer j;

	// button conditioning
	wire [5:0] btn_raw = {btn_acq, btn_beam, btn_dis, btn_mode, btn_gas, btn_prog};
	wire [5:0] held;
	wire [5:0] press;

	genvar g;
	generate
		for (g = 0; g < `PBS_NUM_BTN; g = g + 1)
		begin : deb
			reg s1_q, s2_q, s3_q, lvl_q, prs_q;
			reg [29:0] cnt_q;
			always @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					s1_q <= 1'b0;
					s2_q <= 1'b0;
					s3_q <= 1'b0;
					lvl_q <= 1'b0;
					prs_q <= 1'b0;
					cnt_q <= 30'h0000_0000;
				end
				else
				begin
					s1_q <= btn_raw[g];
					s2_q <= s1_q;
					s3_q <= s2_q;
					prs_q <= 1'b0;
					// a level only counts once it has stayed put for the whole window
					if (s2_q != s3_q || s3_q == lvl_q)
						cnt_q <= 30'h0000_0000;
					else if (cnt_q == DEBOUNCE_CYC - 30'h0000_0001)
					begin
						cnt_q <= 30'h0000_0000;
						lvl_q <= s3_q;
						prs_q <= lvl_q & ~s3_q;
					end
					else
						cnt_q <= cnt_q + 30'h0000_0001;
				end
			end
			assign held[g] = lvl_q;
			assign press[g] = prs_q;
		end
	endgenerate

	// blink and slow tick timebases
	reg [29:0] blink_cnt_q, tick_cnt_q;
	reg blink_q, tick_q;
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			blink_cnt_q <= 30'h0000_0000;
			blink_q <= 1'b0;
			tick_cnt_q <= 30'h0000_0000;
			tick_q <= 1'b0;
		end
		else
		begin
			blink_cnt_q <= (blink_cnt_q == BLINK_CYC - 30'h0000_0001) ? 30'h0000_0000 :
				blink_cnt_q + 30'h0000_0001;
			if (blink_cnt_q == BLINK_CYC - 30'h0000_0001)
				blink_q <= ~blink_q;
			tick_q <= (tick_cnt_q == TICK_CYC - 30'h0000_0001);
			tick_cnt_q <= tick_q ? 30'h0000_0000 : tick_cnt_q + 30'h0000_0001;
		end
	end

	// setpoint store: {slot, field}, slot 4 is the edit slot
	reg [15:0] mem [0:`PBS_MEM_WORDS-1];
	reg [15:0] run_val [0:7];

	reg [1:0] mode_q, st_q, gas_ch_q, edit_base_q;
	reg [2:0] sel_q, run_slot_q, view_sel_q;
	reg edit_q, preview_q;
	reg [29:0] prev_cnt_q;
	reg copy_busy_q;
	reg [2:0] copy_idx_q, acq_idx_q;

	// next slot for a program press; the edit slot joins the cycle while active
	function [2:0] nxt;
		input [2:0] s;
		input ea;
		input [1:0] base;
		reg [1:0] p;
		begin
			p = s[1:0] + 2'h1;
			if (s == `PBS_SLOT_EDIT)
				nxt = {1'b0, base};
			else if (ea && p == base)
				nxt = `PBS_SLOT_EDIT;
			else
				nxt = {1'b0, p};
		end
	endfunction

	// apb decode
	wire acc = psel & penable;
	wire adj_wr = acc & pwrite & (paddr == `PBS_REG_ADJ);
	wire [2:0] adj_fld = pwdata[`PBS_ADJ_FLD_MSB:`PBS_ADJ_FLD_LSB];
	wire adj_refused = (adj_fld == `PBS_FLD_RF) && (mode_q == `PBS_MODE_CLOSED) &&
		(st_q != `PBS_ST_STBY);
	wire mapped = (paddr == `PBS_REG_STATUS) | (paddr == `PBS_REG_ADJ) |
		(paddr == `PBS_REG_VIEW_SEL) | (paddr == `PBS_REG_VIEW) | (paddr == `PBS_REG_RUN);
	// an edit into an inactive slot first waits for the program to be copied in
	wire adj_wait = adj_wr & ~adj_refused & ~edit_q;
	wire adj_take = acc & pready & adj_wr & ~adj_refused;
	wire copy_done = copy_busy_q & (copy_idx_q == `PBS_FLD_LAST);
	wire acq_go = held[`PBS_BTN_ACQ] & edit_q & ~copy_busy_q;
	wire acq_done = acq_go & (acq_idx_q == `PBS_FLD_LAST);
	wire running = (st_q != `PBS_ST_STBY);
	wire [2:0] show = (preview_q | ~running) ? sel_q : run_slot_q;

	// sequencing state
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mode_q <= `PBS_MODE_CLOSED;
			st_q <= `PBS_ST_STBY;
			gas_ch_q <= 2'h0;
			sel_q <= 3'h0;
			run_slot_q <= 3'h0;
			edit_q <= 1'b0;
			edit_base_q <= 2'h0;
			preview_q <= 1'b0;
			prev_cnt_q <= 30'h0000_0000;
		end
		else
		begin
			if (press[`PBS_BTN_GAS])
				gas_ch_q <= gas_ch_q + 2'h1;
			if (press[`PBS_BTN_MODE] && !running)
				mode_q <= (mode_q == `PBS_MODE_OPEN) ? `PBS_MODE_GAS : mode_q + 2'h1;

			// program selection and preview
			if (press[`PBS_BTN_PROG])
			begin
				if (running)
				begin
					preview_q <= 1'b1;
					prev_cnt_q <= 30'h0000_0000;
					sel_q <= nxt(preview_q ? sel_q : run_slot_q, edit_q, edit_base_q);
				end
				else
					sel_q <= nxt(sel_q, edit_q, edit_base_q);
			end
			else if (preview_q)
			begin
				if (prev_cnt_q == PREVIEW_CYC - 30'h0000_0001)
				begin
					preview_q <= 1'b0;
					if (sel_q != run_slot_q)
					begin
						run_slot_q <= sel_q;
						if (edit_q && sel_q != `PBS_SLOT_EDIT)
							edit_q <= 1'b0;
					end
				end
				else
					prev_cnt_q <= prev_cnt_q + 30'h0000_0001;
			end

			// enables
			if (press[`PBS_BTN_DIS])
			begin
				if (running)
				begin
					st_q <= `PBS_ST_STBY;
					preview_q <= 1'b0;
				end
				else if (mode_q != `PBS_MODE_OPEN)
					st_q <= `PBS_ST_DIS;
			end
			else if (press[`PBS_BTN_BEAM] && mode_q != `PBS_MODE_GAS)
			begin
				if (st_q == `PBS_ST_BEAM && mode_q == `PBS_MODE_CLOSED)
					st_q <= `PBS_ST_DIS;
				else if (st_q != `PBS_ST_BEAM)
					st_q <= `PBS_ST_BEAM;
			end

			// starting from standby runs the chosen slot
			if (!running && (press[`PBS_BTN_DIS] || press[`PBS_BTN_BEAM]))
			begin
				run_slot_q <= sel_q;
				if (edit_q && sel_q != `PBS_SLOT_EDIT)
					edit_q <= 1'b0;
			end

			// edit slot; a fresh edit wins over any discard in the same cycle
			if (acq_done)
			begin
				edit_q <= 1'b0;
				sel_q <= {1'b0, edit_base_q};
				if (run_slot_q == `PBS_SLOT_EDIT)
					run_slot_q <= {1'b0, edit_base_q};
			end
			if (copy_done)
			begin
				edit_q <= 1'b1;
				edit_base_q <= show[1:0];
				sel_q <= `PBS_SLOT_EDIT;
				preview_q <= 1'b0;
				if (running)
					run_slot_q <= `PBS_SLOT_EDIT;
			end
		end
	end

	// store writes: program copy, acquire and edits
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (i = 0; i < `PBS_MEM_WORDS; i = i + 1)
				mem[i] <= `PBS_PROG_DEFAULT;
			copy_busy_q <= 1'b0;
			copy_idx_q <= 3'h0;
			acq_idx_q <= 3'h0;
		end
		else
		begin
			if (copy_busy_q)
			begin
				mem[{`PBS_SLOT_EDIT, copy_idx_q}] <= mem[{show, copy_idx_q}];
				copy_idx_q <= copy_idx_q + 3'h1;
				if (copy_done)
					copy_busy_q <= 1'b0;
			end
			else if (adj_wait && !pready)
				copy_busy_q <= 1'b1;
			else if (adj_take)
				mem[{`PBS_SLOT_EDIT, adj_fld}] <= pwdata[`PBS_ADJ_VAL_MSB:0];
			// releasing acquire early abandons the copy; the next hold restarts it
			if (acq_go)
			begin
				mem[{1'b0, edit_base_q, acq_idx_q}] <= mem[{`PBS_SLOT_EDIT, acq_idx_q}];
				acq_idx_q <= acq_idx_q + 3'h1;
			end
			else
				acq_idx_q <= 3'h0;
		end
	end

	// running values ramp toward the running slot; rf follows beam current in closed loop
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (j = 0; j < 8; j = j + 1)
				run_val[j] <= 16'h0000;
		end
		else if (tick_q && running)
		begin
			for (j = 0; j < 8; j = j + 1)
			begin
				if (j == `PBS_FLD_RF && mode_q == `PBS_MODE_CLOSED &&
					st_q == `PBS_ST_BEAM && at_setpoint)
				begin
					// open-loop and gas-only never reach this branch
					if (beam_meas < mem[{run_slot_q, `PBS_FLD_BEAM_I}] && run_val[j] != 16'hffff)
						run_val[j] <= run_val[j] + 16'h0001;
					else if (beam_meas > mem[{run_slot_q, `PBS_FLD_BEAM_I}] &&
						run_val[j] != 16'h0000)
						run_val[j] <= run_val[j] - 16'h0001;
				end
				else if (run_val[j] < mem[{run_slot_q, j[2:0]}])
					run_val[j] <= run_val[j] + 16'h0001;
				else if (run_val[j] > mem[{run_slot_q, j[2:0]}])
					run_val[j] <= run_val[j] - 16'h0001;
			end
		end
	end

	// supply stream and panel outputs
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			dis_en_q <= 1'b0;
			beam_en_q <= 1'b0;
			sp_field_q <= 3'h0;
			sp_value_q <= 16'h0000;
			sp_valid_q <= 1'b0;
			prog_led_q <= 4'h0;
			mode_led_q <= 3'h0;
			standby_led_q <= 1'b1;
			discharge_led_q <= 1'b0;
			beam_led_q <= 1'b0;
			setpoint_led_q <= 1'b1;
			run_led_q <= 1'b0;
			gas_led_q <= 4'h0;
			disp_gas_q <= 16'h0000;
			fault_code_display_q <= 4'h0;
		end
		else
		begin
			dis_en_q <= running;
			beam_en_q <= (st_q == `PBS_ST_BEAM);
			sp_field_q <= sp_field_q + 3'h1;
			sp_value_q <= run_val[sp_field_q];
			sp_valid_q <= running;
			if (show == `PBS_SLOT_EDIT && blink_q)
				prog_led_q <= 4'h0;
			else
				prog_led_q <= 4'h1 << show[1:0];
			mode_led_q <= 3'h1 << mode_q;
			standby_led_q <= ~running;
			discharge_led_q <= running & (at_setpoint | blink_q);
			beam_led_q <= (st_q == `PBS_ST_BEAM) & (at_setpoint | blink_q);
			setpoint_led_q <= ~running;
			run_led_q <= running;
			gas_led_q <= 4'h1 << gas_ch_q;
			if (running && !preview_q)
				disp_gas_q <= run_val[{1'b0, gas_ch_q}];
			else
				disp_gas_q <= mem[{show, 1'b0, gas_ch_q}];
			fault_code_display_q <= (~&link_ok && blink_q) ? `PBS_FAULT_LINK : 4'h0;
		end
	end

	// apb slave: one wait state, longer while an edit waits for its copy
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			view_sel_q <= 3'h0;
		end
		else
		begin
			pready <= acc & ~pready & ~(adj_wait | copy_busy_q);
			// the error flag only stands beside the ready pulse
			pslverr <= 1'b0;
			if (acc && !pready)
			begin
				pslverr <= ~mapped | (adj_wr & adj_refused);
				prdata <= 32'h0000_0000;
				if (!pwrite)
				begin
					case (paddr)
					`PBS_REG_STATUS:
						prdata <= {15'h0000, fault_code_display_q, ~&link_ok, preview_q, edit_q,
							run_slot_q, sel_q, st_q, mode_q};
					`PBS_REG_VIEW_SEL:
						prdata <= {29'h0000_0000, view_sel_q};
					`PBS_REG_VIEW:
						prdata <= {16'h0000, mem[{(view_sel_q == `PBS_FLD_RF) ?
							run_slot_q : show, view_sel_q}]};
					`PBS_REG_RUN:
						prdata <= {16'h0000, run_val[view_sel_q]};
					default:
						prdata <= 32'h0000_0000;
					endcase
				end
			end
			if (acc && pready && pwrite && paddr == `PBS_REG_VIEW_SEL)
				view_sel_q <= pwdata[2:0];
		end
	end

endmodule

`default_nettype wire

// File: rtl/pbs_defs.vh
// constants shared by the program and beam sequencer
`ifndef PBS_DEFS_VH
`define PBS_DEFS_VH

// clock rate and times, in their own units
`define PBS_CLK_KHZ 200000
`define PBS_PREVIEW_MS 4000
`define PBS_DEBOUNCE_MS 10
`define PBS_BLINK_MS 250
`define PBS_TICK_MS 1

// apb register byte offsets
`define PBS_REG_STATUS 8'h00
`define PBS_REG_ADJ 8'h04
`define PBS_REG_VIEW_SEL 8'h08
`define PBS_REG_VIEW 8'h0c
`define PBS_REG_RUN 8'h10

// adjust register layout
`define PBS_ADJ_VAL_MSB 15
`define PBS_ADJ_FLD_LSB 16
`define PBS_ADJ_FLD_MSB 18

// setpoint fields of a program: 0..3 are the gas channels
`define PBS_FLD_DISCHARGE 3'h4
`define PBS_FLD_EMISSION 3'h5
`define PBS_FLD_BEAM_I 3'h6
`define PBS_FLD_RF 3'h7
`define PBS_FLD_LAST 3'h7

// slots: four stored programs and the edit slot
`define PBS_SLOT_EDIT 3'h4
`define PBS_MEM_WORDS 40
`define PBS_PROG_DEFAULT 16'h0000

// operating modes
`define PBS_MODE_GAS 2'h0
`define PBS_MODE_CLOSED 2'h1
`define PBS_MODE_OPEN 2'h2

// enable states
`define PBS_ST_STBY 2'h0
`define PBS_ST_DIS 2'h1
`define PBS_ST_BEAM 2'h2

// panel fault code shown when a supply link is missing
`define PBS_FAULT_LINK 4'h9

`define PBS_NUM_BTN 6
`define PBS_BTN_PROG 0
`define PBS_BTN_GAS 1
`define PBS_BTN_MODE 2
`define PBS_BTN_DIS 3
`define PBS_BTN_BEAM 4
`define PBS_BTN_ACQ 5

`endif

// File: sim/pbs_props.sv
// port assertions for the program and beam sequencer
`timescale 1ns/100ps
`default_nettype none
`include "pbs_defs.vh"
module pbs_props (
	// clock and bus answer
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pready,
	input wire pslverr,
	// supplies and panel
	input wire [3:0] link_ok,
	input wire at_setpoint,
	input wire dis_en_q,
	input wire beam_en_q,
	input wire sp_valid_q,
	input wire [2:0] sp_field_q,
	input wire [2:0] mode_led_q,
	input wire standby_led_q,
	input wire discharge_led_q,
	input wire run_led_q,
	input wire [3:0] fault_code_display_q
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready stood two cycles");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_ready_bound: assert property (psel && penable && !pready |-> ##[1:20] pready)
		else $error("access not answered");
	a_beam_interlock: assert property (beam_en_q |-> dis_en_q)
		else $error("beam enabled without discharge");
	a_standby_led: assert property (standby_led_q == !dis_en_q)
		else $error("standby led disagrees with enable");
	a_run_led: assert property (run_led_q == dis_en_q && sp_valid_q == dis_en_q)
		else $error("run led or stream valid disagrees with enable");
	a_mode_frozen: assert property (dis_en_q |-> $stable(mode_led_q))
		else $error("mode changed while enabled");
	a_led_steady: assert property ((dis_en_q && at_setpoint)[*3] |-> discharge_led_q)
		else $error("discharge led dark at setpoint");
	a_fault_clear: assert property ((&link_ok)[*4] |-> fault_code_display_q == 4'h0)
		else $error("fault code with all links up");
	a_field_step: assert property ($past(presetn) |-> sp_field_q == $past(sp_field_q) + 3'h1)
		else $error("supply stream field did not step");
	a_fault_value: assert property (fault_code_display_q == 4'h0
		|| fault_code_display_q == `PBS_FAULT_LINK)
		else $error("unexpected fault code");
	c_beam: cover property (beam_en_q && at_setpoint);
	c_refused: cover property (pslverr);
	c_fault: cover property (fault_code_display_q == `PBS_FAULT_LINK);
endmodule
bind pbs_sequencer pbs_props i_pbs_props (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pready(pready), .pslverr(pslverr), .link_ok(link_ok),
	.at_setpoint(at_setpoint), .dis_en_q(dis_en_q), .beam_en_q(beam_en_q),
	.sp_valid_q(sp_valid_q), .sp_field_q(sp_field_q), .mode_led_q(mode_led_q),
	.standby_led_q(standby_led_q),
	.discharge_led_q(discharge_led_q), .run_led_q(run_led_q),
	.fault_code_display_q(fault_code_display_q));
`default_nettype wire

// File: sim/pbs_supply.sv
// supply-side model: links, settling and beam current
`timescale 1ns/100ps
`default_nettype none
module pbs_supply #(
	parameter int SETTLE = 12
)(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// enables from the sequencer, link fault request from the bench
	input wire logic dis_en_q,
	input wire logic beam_en_q,
	input wire logic link_drop,
	// answers
	output logic [3:0] link_ok,
	output logic at_setpoint,
	output logic [15:0] beam_meas
);
	logic [7:0] age_q;
	// supplies settle slowly so the enable leds must blink first
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			age_q <= 8'h00;
			at_setpoint <= 1'h0;
			beam_meas <= 16'h0000;
			link_ok <= 4'hf;
		end
		else
		begin
			age_q <= !dis_en_q ? 8'h00 : (age_q == SETTLE ? age_q : age_q + 8'h01);
			at_setpoint <= dis_en_q && age_q == SETTLE;
			beam_meas <= beam_en_q ? {8'h00, age_q} + 16'h0040 : 16'h0000;
			link_ok <= link_drop ? 4'hb : 4'hf;
		end
	end
endmodule
`default_nettype wire

// File: sim/program_beam_sequencer_bench.sv
// self-checking bench for the program and beam sequencer
`timescale 1ns/100ps
`default_nettype none
`include "pbs_defs.vh"
module program_beam_sequencer_bench;
	localparam logic [29:0] DEB = 30'h0000_0004;
	localparam logic [29:0] PRV = 30'h0000_00c8;
	logic pclk = 1'h0;
	logic presetn = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic link_drop = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [5:0] btn = 6'h00;
	logic [31:0] seed = 32'h0000_fd7e;
	logic [31:0] rd;
	logic err;
	logic saw9;
	logic [15:0] v;
	int errors = 0;
	int checks = 0;
	wire [31:0] prdata;
	wire pready, pslverr, at_setpoint, dis_en_q, beam_en_q, standby_led_q, run_led_q;
	wire setpoint_led_q, beam_led_q;
	wire [15:0] sp_value_q;
	wire [3:0] link_ok, prog_led_q, gas_led_q, fault_code_display_q;
	wire [2:0] mode_led_q;
	wire [15:0] beam_meas, disp_gas_q;

	always #2.5 pclk = ~pclk;

	pbs_sequencer #(.PREVIEW_CYC(PRV), .DEBOUNCE_CYC(DEB), .BLINK_CYC(30'h0000_0008),
		.TICK_CYC(30'h0000_0004)) i_pbs_sequencer (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .btn_prog(btn[0]),
		.btn_gas(btn[1]), .btn_mode(btn[2]), .btn_dis(btn[3]), .btn_beam(btn[4]),
		.btn_acq(btn[5]), .link_ok(link_ok), .at_setpoint(at_setpoint),
		.beam_meas(beam_meas), .dis_en_q(dis_en_q), .beam_en_q(beam_en_q), .sp_field_q(),
		.sp_value_q(sp_value_q), .sp_valid_q(), .prog_led_q(prog_led_q),
		.mode_led_q(mode_led_q), .standby_led_q(standby_led_q), .discharge_led_q(),
		.beam_led_q(beam_led_q), .setpoint_led_q(setpoint_led_q), .run_led_q(run_led_q),
		.gas_led_q(gas_led_q),
		.disp_gas_q(disp_gas_q), .fault_code_display_q(fault_code_display_q));

	pbs_supply i_pbs_supply (.pclk(pclk), .presetn(presetn), .dis_en_q(dis_en_q),
		.beam_en_q(beam_en_q), .link_drop(link_drop), .link_ok(link_ok),
		.at_setpoint(at_setpoint), .beam_meas(beam_meas));

	function automatic logic [31:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// pready, read data and error are taken at the rising edge that ends the access
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'h1 && n < 50);
		if (n >= 50)
			errors++;
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task automatic press(input int b);
		@(posedge pclk);
		btn[b] <= 1'h1;
		repeat (DEB + 10) @(posedge pclk);
		btn[b] <= 1'h0;
		repeat (DEB + 14) @(posedge pclk);
	endtask

	task automatic stop_test();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial
	begin
		repeat (10) @(posedge pclk);
		presetn <= 1'h1;
		repeat (3) @(posedge pclk);
		check("mode_led", mode_led_q, 3'h2);
		check("prog_led", prog_led_q, 4'h1);
		check("standby_led", standby_led_q, 1'h1);
		check("setpoint_led", setpoint_led_q, 1'h1);
		check("sp_value", sp_value_q, 16'h0000);
		apb(1'h0, 8'h20, 32'h0000_0000);
		check("unmapped", err, 1'h1);
		apb(1'h0, `PBS_REG_STATUS, 32'h0000_0000);
		check("edit after reset", rd[10], 1'h0);
		for (int i = 1; i <= 4; i++)
		begin
			press(`PBS_BTN_PROG);
			check("prog_led", prog_led_q, 4'h1 << (i % 4));
			press(`PBS_BTN_GAS);
			check("gas_led", gas_led_q, 4'h1 << (i % 4));
		end
		for (int i = 1; i <= 3; i++)
		begin
			press(`PBS_BTN_MODE);
			check("mode_led", mode_led_q, 3'h1 << ((i + 1) % 3));
		end
		$display("end panel cycling");
		v = 16'(rnd());
		apb(1'h1, `PBS_REG_ADJ, {16'h0000, v});
		apb(1'h0, `PBS_REG_STATUS, 32'h0000_0000);
		check("edit active", rd[10], 1'h1);
		check("edit gas", disp_gas_q, v);
		for (int i = 1; i <= 5; i++)
		begin
			press(`PBS_BTN_PROG);
			apb(1'h0, `PBS_REG_STATUS, 32'h0000_0000);
			check("shown slot", rd[6:4], i == 5 ? 4 : i - 1);
		end
		check("edit gas back", disp_gas_q, v);
		btn[`PBS_BTN_ACQ] <= 1'h1;
		repeat (DEB + 30) @(posedge pclk);
		btn[`PBS_BTN_ACQ] <= 1'h0;
		repeat (DEB + 20) @(posedge pclk);
		apb(1'h0, `PBS_REG_STATUS, 32'h0000_0000);
		check("edit cleared", rd[10], 1'h0);
		check("stored gas", disp_gas_q, v);
		$display("end edit slot");
		press(`PBS_BTN_BEAM);
		check("beam start", {dis_en_q, beam_en_q, standby_led_q, run_led_q}, 4'hd);
		check("setpoint_led run", setpoint_led_q, 1'h0);
		apb(1'h1, `PBS_REG_ADJ, 32'h0007_0123);
		check("rf refused", err, 1'h1);
		press(`PBS_BTN_MODE);
		check("mode kept", mode_led_q, 3'h2);
		check("beam led steady", beam_led_q, 1'h1);
		press(`PBS_BTN_PROG);
		apb(1'h0, `PBS_REG_STATUS, 32'h0000_0000);
		check("preview", rd[11:4], 8'h81);
		press(`PBS_BTN_PROG);
		apb(1'h0, `PBS_REG_STATUS, 32'h0000_0000);
		check("preview step", rd[11:4], 8'h82);
		repeat (PRV + 40) @(posedge pclk);
		apb(1'h0, `PBS_REG_STATUS, 32'h0000_0000);
		check("switched", rd[11:4], 8'h12);
		repeat (4) press(`PBS_BTN_PROG);
		repeat (PRV + 40) @(posedge pclk);
		apb(1'h0, `PBS_REG_STATUS, 32'h0000_0000);
		check("same program", rd[11:4], 8'h12);
		press(`PBS_BTN_BEAM);
		check("beam stby", {dis_en_q, beam_en_q, standby_led_q}, 3'h4);
		press(`PBS_BTN_BEAM);
		press(`PBS_BTN_DIS);
		check("all stby", {dis_en_q, beam_en_q, standby_led_q}, 3'h1);
		press(`PBS_BTN_DIS);
		check("dis only", {dis_en_q, beam_en_q, standby_led_q}, 3'h4);
		press(`PBS_BTN_DIS);
		press(`PBS_BTN_MODE);
		check("open mode", mode_led_q, 3'h4);
		press(`PBS_BTN_BEAM);
		check("open run", beam_en_q, 1'h1);
		v = 16'(rnd());
		apb(1'h1, `PBS_REG_ADJ, {16'h0007, v});
		check("rf taken", err, 1'h0);
		press(`PBS_BTN_DIS);
		check("open stop", {dis_en_q, beam_en_q, standby_led_q}, 3'h1);
		press(`PBS_BTN_PROG);
		apb(1'h0, `PBS_REG_STATUS, 32'h0000_0000);
		check("revert slot", rd[10:4], 7'h62);
		press(`PBS_BTN_BEAM);
		apb(1'h0, `PBS_REG_STATUS, 32'h0000_0000);
		check("edit dropped", rd[10:4], 7'h12);
		press(`PBS_BTN_DIS);
		$display("end enables");
		link_drop <= 1'h1;
		saw9 = 1'h0;
		repeat (40)
		begin
			@(negedge pclk);
			saw9 = saw9 | (fault_code_display_q === `PBS_FAULT_LINK);
		end
		check("fault code", saw9, 1'h1);
		apb(1'h0, `PBS_REG_STATUS, 32'h0000_0000);
		check("link fault", rd[12], 1'h1);
		link_drop <= 1'h0;
		repeat (20) @(posedge pclk);
		$display("end link fault");
		stop_test();
	end

	initial
	begin
		repeat (20000) @(posedge pclk);
		errors++;
		$display("watchdog expired");
		stop_test();
	end
endmodule
`default_nettype wire
